// file: common/csdb_pkg.sv
package csdb_pkg;
  // Register map, byte addresses on the control port
  localparam logic [6:0] CTRL2_ADDR = 7'h02;
  localparam logic [6:0] IRQ_EN_ADDR = 7'h04;
  localparam logic [6:0] IRQ_STAT_ADDR = 7'h0b;
  localparam logic [6:0] CS_BASE_ADDR = 7'h19;
  localparam logic [6:0] CS_LAST_ADDR = 7'h22;
  // Fields
  localparam int INHIBIT_BIT = 6;
  localparam int XFER_IE_BIT = 5;
  localparam int XFER_IS_BIT = 5;
  // Reset values
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [7:0] IRQ_EN_RST = 8'h00;
  // Sizes
  localparam int CS_BYTES = 5;
  localparam int BLOCK_FRAMES = 192;
  localparam int CAP_BITS = 40;
endpackage : csdb_pkg

// file: common/csdb_word_if.sv
`timescale 1ns/1ns
interface csdb_word_if;
  logic valid;
  logic ready;
  logic [79:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface : csdb_word_if

// file: hdl/csdb_skid.sv
`timescale 1ns/1ns
module csdb_skid #(
  parameter int WIDTH = 80
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  csdb_word_if.dst in_port,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  logic [WIDTH-1:0] mem_r [2];
  logic [1:0] cnt_r;
  logic wp_r;
  logic rp_r;
  logic push;
  logic pop;

  assign in_port.ready = cnt_r != 2'd2;
  assign out_valid = cnt_r != 2'd0;
  assign out_data = mem_r[rp_r];
  assign push = in_port.valid && in_port.ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_port.data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= 2'd0;
      wp_r <= 1'b0;
      rp_r <= 1'b0;
    end else begin
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
      if (push) begin
        wp_r <= ~wp_r;
      end
      if (pop) begin
        rp_r <= ~rp_r;
      end
    end
  end
endmodule : csdb_skid

// file: hdl/csdb_top.sv
`timescale 1ns/1ns
module csdb_top (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // Decoded stream from receiver, same clock
  input wire logic CS_BIT_VALID,
  input wire logic CS_BIT,
  input wire logic CS_BIT_CHAN_B,
  input wire logic BLOCK_START,
  // Output frame clock pin
  input wire logic OUTPUT_FRAME_CLOCK,
  // Mode strap and output selection
  input wire logic HW_MODE,
  input wire logic [1:0] GENERAL_OUTPUT_SEL,
  // Control port
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [6:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  // Outputs
  output logic INT_OUT,
  output logic CS_SERIAL_PIN,
  output logic [2:0] GENERAL_OUTPUT_PIN,
  output logic COPY_PIN,
  output logic ORIGINAL_FLAG_PIN
);
  csdb_word_if blk_if ();

  logic [39:0] cap_a_r;
  logic [39:0] cap_b_r;
  logic [5:0] cnt_a_r;
  logic [5:0] cnt_b_r;
  logic [7:0] frame_cnt_r;
  logic block_done;
  logic [39:0] host_a_r;
  logic [39:0] host_b_r;
  logic [7:0] ctrl2_r;
  logic [7:0] irq_en_r;
  logic [7:0] irq_stat_r;
  logic hold_r;
  logic sk_valid;
  logic [79:0] sk_data;
  logic sk_ready;
  logic xfer;
  logic stat_rd;
  logic [7:0] rd_nxt;
  logic lr_s1_r;
  logic lr_s2_r;
  logic lr_s3_r;
  logic lr_edge;
  logic [79:0] ser_r;
  logic ser_bit_r;
  logic [39:0] ser_chan_a;

  // Capture stage, fills MSB first and counts frames
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      cap_a_r <= 40'h0;
      cap_b_r <= 40'h0;
      cnt_a_r <= 6'h0;
      cnt_b_r <= 6'h0;
    end else if (BLOCK_START) begin
      cnt_a_r <= 6'h0;
      cnt_b_r <= 6'h0;
    end else if (CS_BIT_VALID) begin
      if (!CS_BIT_CHAN_B && cnt_a_r < 6'(csdb_pkg::CAP_BITS)) begin
        cap_a_r[39 - cnt_a_r] <= CS_BIT;
        cnt_a_r <= cnt_a_r + 6'h1;
      end
      if (CS_BIT_CHAN_B && cnt_b_r < 6'(csdb_pkg::CAP_BITS)) begin
        cap_b_r[39 - cnt_b_r] <= CS_BIT;
        cnt_b_r <= cnt_b_r + 6'h1;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      frame_cnt_r <= 8'h0;
    end else if (BLOCK_START) begin
      frame_cnt_r <= 8'h0;
    end else if (CS_BIT_VALID && CS_BIT_CHAN_B
        && frame_cnt_r != 8'(csdb_pkg::BLOCK_FRAMES)) begin
      frame_cnt_r <= frame_cnt_r + 8'h1;
    end
  end

  // Whole block complete on the 192nd frame after BLOCK_START, once until the next BLOCK_START
  assign block_done = CS_BIT_VALID && CS_BIT_CHAN_B
    && frame_cnt_r == 8'(csdb_pkg::BLOCK_FRAMES - 1);

  // Offer block to buffer unless inhibited; skipped blocks are dropped
  assign blk_if.valid = block_done && !ctrl2_r[csdb_pkg::INHIBIT_BIT];
  assign blk_if.data = {cap_a_r, cap_b_r};
  csdb_skid #(
    .WIDTH(80)
  ) u_skid (
    .clk(CLOCK),
    .rst(RESET),
    .in_port(blk_if.dst),
    .out_valid(sk_valid),
    .out_data(sk_data),
    .out_ready(sk_ready)
  );

  // Host stage loads complete blocks only, stalls while inhibited
  assign sk_ready = !ctrl2_r[csdb_pkg::INHIBIT_BIT] && !hold_r;
  assign xfer = sk_valid && sk_ready;

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      host_a_r <= 40'h0;
      host_b_r <= 40'h0;
    end else if (xfer) begin
      host_a_r <= sk_data[79:40];
      host_b_r <= sk_data[39:0];
    end
  end

  // One-cycle guard so back-to-back entries never merge
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      hold_r <= 1'b0;
    end else begin
      hold_r <= xfer;
    end
  end

  // Control registers
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      ctrl2_r <= csdb_pkg::CTRL2_RST;
      irq_en_r <= csdb_pkg::IRQ_EN_RST;
    end else if (REG_WR) begin
      if (REG_ADDR == csdb_pkg::CTRL2_ADDR) begin
        ctrl2_r <= REG_WDATA;
      end
      if (REG_ADDR == csdb_pkg::IRQ_EN_ADDR) begin
        irq_en_r <= REG_WDATA;
      end
    end
  end

  // Sticky transfer flag, cleared by reading status; set wins
  assign stat_rd = REG_RD && REG_ADDR == csdb_pkg::IRQ_STAT_ADDR;
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      irq_stat_r <= 8'h0;
    end else if (xfer) begin
      irq_stat_r[csdb_pkg::XFER_IS_BIT] <= 1'b1;
    end else if (stat_rd) begin
      irq_stat_r <= 8'h0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      INT_OUT <= 1'b0;
    end else begin
      INT_OUT <= |(irq_stat_r & irq_en_r & (8'h1 << csdb_pkg::XFER_IE_BIT));
    end
  end

  // Read decode
  always_comb begin
    rd_nxt = 8'h00;
    if (REG_ADDR == csdb_pkg::CTRL2_ADDR) begin
      rd_nxt = ctrl2_r;
    end else if (REG_ADDR == csdb_pkg::IRQ_EN_ADDR) begin
      rd_nxt = irq_en_r;
    end else if (REG_ADDR == csdb_pkg::IRQ_STAT_ADDR) begin
      rd_nxt = irq_stat_r;
    end else if (REG_ADDR >= csdb_pkg::CS_BASE_ADDR && REG_ADDR <= csdb_pkg::CS_LAST_ADDR) begin
      rd_nxt = host_sel(7'(REG_ADDR - csdb_pkg::CS_BASE_ADDR));
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      REG_RDATA <= rd_nxt;
    end
  end

  function automatic logic [7:0] host_sel(input logic [6:0] idx);
    logic [79:0] all;
    all = {host_a_r, host_b_r};
    host_sel = all[79 - 8 * idx -: 8];
  endfunction : host_sel

  // Frame clock pin synchroniser and edge detect
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      lr_s1_r <= 1'b0;
      lr_s2_r <= 1'b0;
      lr_s3_r <= 1'b0;
    end else begin
      lr_s1_r <= OUTPUT_FRAME_CLOCK;
      lr_s2_r <= lr_s1_r;
      lr_s3_r <= lr_s2_r;
    end
  end
  assign lr_edge = lr_s2_r ^ lr_s3_r;

  // Serial status shifter, reloads from skid buffer output on each transfer
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      ser_r <= 80'h0;
      ser_bit_r <= 1'b0;
    end else if (xfer) begin
      ser_r <= sk_data;
    end else if (lr_edge) begin
      ser_bit_r <= ser_r[79];
      ser_r <= {ser_r[78:0], ser_r[79]};
    end
  end

  assign ser_chan_a = host_a_r;

  // Pin routing by mode
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      CS_SERIAL_PIN <= 1'b0;
      GENERAL_OUTPUT_PIN <= 3'h0;
      COPY_PIN <= 1'b0;
      ORIGINAL_FLAG_PIN <= 1'b0;
    end else begin
      CS_SERIAL_PIN <= HW_MODE ? ser_bit_r : 1'b0;
      GENERAL_OUTPUT_PIN <= 3'h0;
      if (!HW_MODE && GENERAL_OUTPUT_SEL != 2'd3) begin
        GENERAL_OUTPUT_PIN[GENERAL_OUTPUT_SEL] <= ser_bit_r;
      end
      // Copy permitted bit and original flag from consumer layout
      COPY_PIN <= HW_MODE && ser_chan_a[37];
      ORIGINAL_FLAG_PIN <= HW_MODE && ser_chan_a[24];
    end
  end
endmodule : csdb_top

// file: tb/csdb_checker_assertions.sv
`timescale 1ns/1ns
module csdb_checker (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // Control port
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [6:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  // Interrupt
  input wire logic INT_OUT
);
  logic inh_r;
  logic ien_r;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  // Shadow of inhibit and enable bits
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      inh_r <= 1'b0;
      ien_r <= 1'b0;
    end else if (REG_WR && REG_ADDR == csdb_pkg::CTRL2_ADDR) begin
      inh_r <= REG_WDATA[csdb_pkg::INHIBIT_BIT];
    end else if (REG_WR && REG_ADDR == csdb_pkg::IRQ_EN_ADDR) begin
      ien_r <= REG_WDATA[csdb_pkg::XFER_IE_BIT];
    end
  end
  rst_quiet_a: assert property (disable iff (1'b0) RESET |=> REG_RDATA == 8'h00 && !INT_OUT)
    else $error("outputs not cleared by reset");
  unmapped_zero_a: assert property (REG_RD && REG_ADDR > csdb_pkg::CS_LAST_ADDR |=>
    REG_RDATA == 8'h00) else $error("unmapped read not zero");
  rdata_holds_a: assert property (!$past(REG_RD) |-> $stable(REG_RDATA))
    else $error("read data moved without read");
  stat_clear_a: assert property (REG_RD && REG_ADDR == csdb_pkg::IRQ_STAT_ADDR |-> ##2 !INT_OUT)
    else $error("interrupt not cleared by status read");
  int_mask_a: assert property (REG_WR && REG_ADDR == csdb_pkg::IRQ_EN_ADDR &&
    !REG_WDATA[csdb_pkg::XFER_IE_BIT] |-> ##2 !INT_OUT) else $error("masked interrupt stays");
  int_enable_a: assert property ($rose(INT_OUT) |-> ien_r)
    else $error("interrupt without enable");
  int_inhibit_a: assert property ($rose(INT_OUT) |-> !$past(inh_r, 3))
    else $error("transfer while inhibited");
  int_stands_a: assert property ($fell(INT_OUT) |-> $past(REG_RD) || $past(REG_RD, 2) ||
    $past(REG_WR) || $past(REG_WR, 2)) else $error("interrupt dropped by itself");
endmodule : csdb_checker
bind csdb_top csdb_checker chk_u (.CLOCK(CLOCK), .RESET(RESET), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
  .INT_OUT(INT_OUT));

// file: tb/csdb_rx_model.sv
`timescale 1ns/1ns
module csdb_rx_model (
  // Clock
  input wire logic clk,
  // Decoded status stream
  output logic valid = 1'b0,
  output logic cs_bit = 1'b0,
  output logic chan_b = 1'b0,
  output logic blk = 1'b0
);
  // One block: A bit then B bit per frame, first bit first
  task send(input logic [79:0] d);
    blk <= 1'b1;
    @(posedge clk) blk <= 1'b0;
    for (int f = 0; f < 192; f++) begin
      valid <= 1'b1;
      chan_b <= 1'b0;
      cs_bit <= (f < 40) ? d[79 - f] : 1'b0;
      @(posedge clk) chan_b <= 1'b1;
      cs_bit <= (f < 40) ? d[39 - f] : 1'b0;
      @(posedge clk) valid <= 1'b0;
      cs_bit <= (f < 40) ? ~d[39 - f] : 1'b1;
      @(posedge clk);
    end
    blk <= 1'b1;
    @(posedge clk) blk <= 1'b0;
  endtask : send
endmodule : csdb_rx_model

// file: tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  localparam logic [79:0] PAT = 80'h8011223344c566778899;
  logic CLOCK = 1'b0;
  logic RESET = 1'b1;
  logic vld, bt, chb, blk, int_out;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [6:0] addr = 7'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic lrck = 1'b0;
  logic hw = 1'b0;
  logic [1:0] sel = 2'h3;
  logic ser_pin, copy_pin, original_flag_pin_pin;
  logic [2:0] general_output_pin;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  initial forever #10 CLOCK = ~CLOCK;
  csdb_rx_model rx_u (.clk(CLOCK), .valid(vld), .cs_bit(bt), .chan_b(chb), .blk(blk));
  csdb_top dut_u (.CLOCK(CLOCK), .RESET(RESET), .CS_BIT_VALID(vld), .CS_BIT(bt),
    .CS_BIT_CHAN_B(chb), .BLOCK_START(blk), .OUTPUT_FRAME_CLOCK(lrck), .HW_MODE(hw),
    .GENERAL_OUTPUT_SEL(sel), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .INT_OUT(int_out), .CS_SERIAL_PIN(ser_pin),
    .GENERAL_OUTPUT_PIN(general_output_pin), .COPY_PIN(copy_pin), .ORIGINAL_FLAG_PIN(original_flag_pin_pin));
  task results;
    if (num_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results
  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wrreg(input logic [6:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge CLOCK) wr <= 1'b0;
    @(posedge CLOCK);
  endtask : wrreg
  task rdreg(input logic [6:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge CLOCK) rd <= 1'b0;
    @(posedge CLOCK) chk(rdata, e);
  endtask : rdreg
  task rdblk(input logic [79:0] p);
    for (int k = 0; k < 10; k++) rdreg(csdb_pkg::CS_BASE_ADDR + 7'(k), p[79-8*k -: 8]);
  endtask : rdblk
  task wint;
    for (int i = 0; i < 20 && int_out !== 1'b1; i++) @(posedge CLOCK);
    chk({7'h00, int_out}, 8'h01);
    rdreg(csdb_pkg::IRQ_STAT_ADDR, 8'h20);
    repeat (2) @(posedge CLOCK);
    chk({7'h00, int_out}, 8'h00);
  endtask : wint
  task t_reset;
    rdreg(csdb_pkg::CTRL2_ADDR, csdb_pkg::CTRL2_RST);
    rdreg(csdb_pkg::IRQ_EN_ADDR, csdb_pkg::IRQ_EN_RST);
    rdreg(7'h7f, 8'h00);
  endtask : t_reset
  task t_xfer;
    wrreg(csdb_pkg::IRQ_EN_ADDR, 8'h20);
    rx_u.send(PAT);
    wint();
    rdblk(PAT);
  endtask : t_xfer
  task t_inhibit;
    wrreg(csdb_pkg::CTRL2_ADDR, 8'h40);
    rx_u.send(~PAT);
    repeat (8) @(posedge CLOCK);
    chk({7'h00, int_out}, 8'h00);
    rdblk(PAT);
    wrreg(csdb_pkg::CTRL2_ADDR, 8'h00);
    rx_u.send(~PAT);
    wint();
    rdblk(~PAT);
  endtask : t_inhibit
  task t_serial;
    logic [79:0] p;
    p = ~PAT;
    hw <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      lrck <= ~lrck;
      repeat (5) @(posedge CLOCK);
      chk({7'h00, ser_pin}, {7'h00, p[79 - k]});
    end
    chk({6'h00, copy_pin, original_flag_pin_pin}, {6'h00, p[77], p[64]});
    hw <= 1'b0;
    sel <= 2'h1;
    for (int k = 8; k < 16; k++) begin
      lrck <= ~lrck;
      repeat (5) @(posedge CLOCK);
      chk({4'h0, ser_pin, general_output_pin}, {4'h0, 1'b0, 1'b0, p[79 - k], 1'b0});
    end
    chk({6'h00, copy_pin, original_flag_pin_pin}, 8'h00);
  endtask : t_serial
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    repeat (3) @(posedge CLOCK);
    RESET <= 1'b0;
    @(posedge CLOCK);
    t_reset();
    t_xfer();
    t_inhibit();
    t_serial();
    results();
  end
endmodule : tb_top
